//--- sep_pkg.sv
// shared constants for the serial memory read path, both bus ends
// assumes nothing beyond a systemverilog compiler
package sep_pkg;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 8;
	localparam int CS_W = 3;
	// device type code of the control byte (arbitrary value)
	localparam logic [3:0] TYPE_CODE = 4'h5;
	localparam logic [ADDR_W-1:0] PTR_RESET = 14'h0000;
	localparam logic [ADDR_W-1:0] PTR_TOP = 14'h3fff;
	localparam logic DIR_READ = 1'h1;
	localparam logic DIR_WRITE = 1'h0;
	// link timing
	localparam int CLK_MHZ = 100;
	localparam int LINK_HALF_NS = 500;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int LINK_CNT_W = 16;
endpackage

//--- sep_link_if.sv
// two-wire link between the memory end and the master end
// assumes open-drain wiring resolved here from the output enables
`timescale 1ns/1ps
`default_nettype none
interface sep_link_if;
	logic sclDrvLowN;  // master: low while pulling clock low
	logic sdaMstOeN;   // master: low while pulling data low
	logic sdaDevOeN;   // memory: low while pulling data low
	logic sclLine;
	logic sdaLine;

	// wired-and of open-drain drivers with pull-ups
	assign sclLine = sclDrvLowN;
	assign sdaLine = sdaMstOeN & sdaDevOeN;

	modport device (input sclLine, input sdaLine, output sdaDevOeN);
	modport master (input sclLine, input sdaLine, output sclDrvLowN, output sdaMstOeN);
endinterface
`default_nettype wire

//--- sep_mem_end.sv
// memory end of the two-wire link: read path, pointer, address load
// assumes a memory array outside with a one-cycle read and a busy flag
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - master reads start like writes, direction one
// - counter holds last accessed location plus one
// - matching read control byte: acknowledge, send byte
// - no acknowledge then stop ends the read
// - random read: address write, then repeated start
// - repeated start loads pointer, stores nothing; here the pointer is loaded at the low address byte
// - master resends control byte with read direction
// - after random read pointer follows returned byte
// - each master acknowledge sends next address byte
// - master ends sequential read with nack, stop
// - pointer increments by one per completed byte
// - pointer wraps from top location to zero
// - control byte: type, chip selects, direction
// - address two bytes high first, fourteen bits
// - no acknowledge during a programming cycle
// - on nack release data line high
module sep_mem_end
	import sep_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	sep_link_if.device             link,
	input  wire logic              chip_select_pin_high,
	input  wire logic              chip_select_pin_mid,
	input  wire logic              chip_select_pin_low,
	input  wire logic              progBusy,
	output logic [ADDR_W-1:0]      memAddr,
	input  wire logic [DATA_W-1:0] memData,
	output logic                   ptrLoaded
);
	typedef enum logic [2:0] {IDLE, CTRL, ADDR_HI, ADDR_LO, WDATA, RDATA, RACK}
		sep_state_e;

	// ************************************************
	// synchronisers and edge detection
	// ************************************************
	logic [1:0] sclSync_r;
	logic [1:0] sdaSync_r;
	logic       sclPrev_r;
	logic       sdaPrev_r;
	logic [2:0] csSync1_r;
	logic [2:0] csSync2_r;
	logic       busySync1_r;
	logic       busySync2_r;

	// two flops on every outside level
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclSync_r <= 2'h3;
			sdaSync_r <= 2'h3;
			sclPrev_r <= 1'h1;
			sdaPrev_r <= 1'h1;
			csSync1_r <= 3'h0;
			csSync2_r <= 3'h0;
			busySync1_r <= 1'h0;
			busySync2_r <= 1'h0;
		end else begin
			sclSync_r <= {sclSync_r[0], link.sclLine};
			sdaSync_r <= {sdaSync_r[0], link.sdaLine};
			sclPrev_r <= sclSync_r[1];
			sdaPrev_r <= sdaSync_r[1];
			csSync1_r <= {chip_select_pin_high, chip_select_pin_mid, chip_select_pin_low};
			csSync2_r <= csSync1_r;
			busySync1_r <= progBusy;
			busySync2_r <= busySync1_r;
		end
	end

	logic scl;
	logic sda;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	assign scl = sclSync_r[1];
	assign sda = sdaSync_r[1];
	assign sclRise = scl & ~sclPrev_r;
	assign sclFall = ~scl & sclPrev_r;
	assign startCond = scl & sclPrev_r & sdaPrev_r & ~sda;
	assign stopCond = scl & sclPrev_r & ~sdaPrev_r & sda;

	// ************************************************
	// byte engine
	// ************************************************
	sep_state_e        state_r;
	logic [3:0]        bitCnt_r;   // 0..7 data bits, 8 = ack slot
	logic [7:0]        shift_r;
	logic [ADDR_W-1:0] ptr_r;
	logic [5:0]        addrHi_r;
	logic              addrSeen_r;
	logic              sdaOeN_r;
	logic              loaded_r;
	logic              ackSlot;
	logic              ctrlMatch;
	assign ackSlot = (bitCnt_r == 4'h8);
	// type code and chip selects both must match
	assign ctrlMatch = (shift_r[7:4] == TYPE_CODE) && (shift_r[3:1] == csSync2_r);

	// sequencing of bytes, ack slots and conditions
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= IDLE;
			bitCnt_r <= 4'h0;
			shift_r <= 8'h00;
			ptr_r <= PTR_RESET;
			addrHi_r <= 6'h00;
			addrSeen_r <= 1'h0;
			sdaOeN_r <= 1'h1;
			loaded_r <= 1'h0;
		end else begin
			loaded_r <= 1'h0;
			if (stopCond) begin
				// release and end transfer
				state_r <= IDLE;
				sdaOeN_r <= 1'h1;
			end else if (startCond) begin
				// repeated start after address: flag pointer loaded (set at low address byte), drop write
				if (addrSeen_r) begin
					loaded_r <= 1'h1;
				end
				addrSeen_r <= 1'h0;
				state_r <= CTRL;
				bitCnt_r <= 4'h0;
				sdaOeN_r <= 1'h1;
			end else if (sclRise) begin
				if (state_r == RACK && ackSlot) begin
					if (sda) begin
						// nack: silent until the next start condition
						state_r <= IDLE;
					end else begin
						// ack asks for the next byte
						state_r <= RDATA;
						shift_r <= memData;
						ptr_r <= ptr_r + 14'h0001; // wraps top to zero
					end
					bitCnt_r <= 4'h0;
				end else if (ackSlot) begin
					// ack clock over, next byte begins
					bitCnt_r <= 4'h0;
				end else if (state_r == RDATA) begin
					bitCnt_r <= bitCnt_r + 4'h1;
				end else if (state_r != IDLE) begin
					shift_r <= {shift_r[6:0], sda};
					bitCnt_r <= bitCnt_r + 4'h1;
				end
			end else if (sclFall) begin
				sdaOeN_r <= 1'h1;
				if (state_r == RDATA && bitCnt_r < 4'h8) begin
					sdaOeN_r <= shift_r[3'h7 - bitCnt_r[2:0]];
					if (bitCnt_r == 4'h7) begin
						state_r <= RACK;
					end
				end else if (ackSlot && state_r != RACK && state_r != IDLE) begin
					// byte received: decide acknowledge; silent when busy
					case (state_r)
						CTRL: begin
							if (ctrlMatch && !busySync2_r) begin
								sdaOeN_r <= 1'h0;
								// read direction streams out from pointer
								state_r <= (shift_r[0] == DIR_READ) ? RDATA : ADDR_HI;
								if (shift_r[0] == DIR_READ) begin
									shift_r <= memData;
									// count stays at the ack slot; its rise clears it
									ptr_r <= ptr_r + 14'h0001;
								end
							end else begin
								state_r <= IDLE;
							end
						end
						ADDR_HI: begin
							// only low fourteen bits kept, high first
							addrHi_r <= shift_r[5:0];
							sdaOeN_r <= busySync2_r; // no ack while busy
							state_r <= ADDR_LO;
						end
						ADDR_LO: begin
							ptr_r <= {addrHi_r, shift_r};
							addrSeen_r <= 1'h1;
							sdaOeN_r <= busySync2_r; // no ack while busy
							state_r <= WDATA;
						end
						WDATA: begin
							// data bytes are not stored by the read path
							addrSeen_r <= 1'h0;
							state_r <= IDLE;
						end
						default: begin
							state_r <= IDLE;
						end
					endcase
				end
			end
		end
	end

	// data shifted out of the first read byte is fetched at the ack slot
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			memAddr <= PTR_RESET;
			ptrLoaded <= 1'h0;
		end else begin
			memAddr <= ptr_r;
			ptrLoaded <= loaded_r;
		end
	end

	assign link.sdaDevOeN = sdaOeN_r;
endmodule
`default_nettype wire

//--- sep_master_end.sv
// master end: issues current, random and sequential reads
// assumes a user that raises reqValid with its fields held until reqReady
`timescale 1ns/1ps
`default_nettype none
module sep_master_end
	import sep_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	sep_link_if.master             link,
	input  wire logic              reqValid,
	input  wire logic              reqRandom,
	input  wire logic [2:0]        reqCs,
	input  wire logic [15:0]       reqAddr,
	input  wire logic [7:0]        reqCount,
	output logic                   reqReady,
	output logic [DATA_W-1:0]      rdData,
	output logic                   rdValid,
	output logic                   nackSeen
);
	typedef enum logic [2:0] {M_IDLE, M_START, M_BYTE, M_STOP} sep_mstate_e;

	logic [1:0] sdaSync_r;
	// data line from outside passes two flops
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sdaSync_r <= 2'h3;
		end else begin
			sdaSync_r <= {sdaSync_r[0], link.sdaLine};
		end
	end

	// quarter-bit tick divider
	logic [LINK_CNT_W-1:0] div_r;
	logic                  tick;
	assign tick = (div_r == LINK_CNT_W'(LINK_HALF_CYC / 2 - 1));
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_r <= '0;
		end else begin
			div_r <= tick ? '0 : div_r + 1'b1;
		end
	end

	sep_mstate_e state_r;
	logic [1:0]  phase_r;
	logic [3:0]  bitCnt_r;
	logic [2:0]  byteIdx_r;   // 0 ctrl w,1 hi,2 lo,3 ctrl r,4 data
	logic [7:0]  tx_r;
	logic [7:0]  rx_r;
	logic [7:0]  left_r;
	logic        sclN_r;
	logic        sdaN_r;
	logic        rdPhase;
	assign rdPhase = (byteIdx_r == 3'h4);

	// transaction sequencer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= M_IDLE;
			phase_r <= 2'h0;
			bitCnt_r <= 4'h0;
			byteIdx_r <= 3'h0;
			tx_r <= 8'h00;
			rx_r <= 8'h00;
			left_r <= 8'h00;
			sclN_r <= 1'h1;
			sdaN_r <= 1'h1;
			reqReady <= 1'h0;
			rdData <= 8'h00;
			rdValid <= 1'h0;
			nackSeen <= 1'h0;
		end else begin
			reqReady <= 1'h0;
			rdValid <= 1'h0;
			if (state_r == M_IDLE) begin
				if (reqValid && !reqReady) begin
					// random reads open with a write-direction address load
					byteIdx_r <= reqRandom ? 3'h0 : 3'h3;
					left_r <= (reqCount == 8'h00) ? 8'h01 : reqCount;
					nackSeen <= 1'h0;
					state_r <= M_START;
					phase_r <= 2'h0;
				end
			end else if (tick) begin
				phase_r <= phase_r + 2'h1;
				case (state_r)
					M_START: begin
						if (phase_r == 2'h0) begin
							sclN_r <= 1'h1;
							sdaN_r <= 1'h1;
						end else if (phase_r == 2'h1) begin
							sdaN_r <= 1'h0;
						end else if (phase_r == 2'h3) begin
							sclN_r <= 1'h0;
							state_r <= M_BYTE;
							bitCnt_r <= 4'h0;
							// control byte with direction bit
							case (byteIdx_r)
								3'h0: tx_r <= {TYPE_CODE, reqCs, DIR_WRITE};
								default: tx_r <= {TYPE_CODE, reqCs, DIR_READ};
							endcase
						end
					end
					M_BYTE: begin
						if (phase_r == 2'h0) begin
							if (bitCnt_r < 4'h8) begin
								sdaN_r <= rdPhase ? 1'h1 : tx_r[3'h7 - bitCnt_r[2:0]];
							end else begin
								// ack for more bytes, nack on last
								sdaN_r <= rdPhase ? (left_r == 8'h01) : 1'h1;
							end
						end else if (phase_r == 2'h1) begin
							sclN_r <= 1'h1;
						end else if (phase_r == 2'h2) begin
							if (bitCnt_r < 4'h8) begin
								rx_r <= {rx_r[6:0], sdaSync_r[1]};
							end else if (!rdPhase && sdaSync_r[1]) begin
								nackSeen <= 1'h1;
							end
						end else begin
							sclN_r <= 1'h0;
							bitCnt_r <= bitCnt_r + 4'h1;
							if (bitCnt_r == 4'h8) begin
								bitCnt_r <= 4'h0;
								if (nackSeen) begin
									state_r <= M_STOP;
								end else if (rdPhase) begin
									rdData <= rx_r;
									rdValid <= 1'h1;
									left_r <= left_r - 8'h01;
									if (left_r == 8'h01) begin
										state_r <= M_STOP;
									end
								end else if (byteIdx_r == 3'h2) begin
									// repeated start in place of data
									byteIdx_r <= 3'h3;
									state_r <= M_START;
								end else begin
									byteIdx_r <= byteIdx_r + 3'h1;
									// top two address bits sent as given, memory ignores them
									tx_r <= (byteIdx_r == 3'h0) ? reqAddr[15:8]
										: (byteIdx_r == 3'h1) ? reqAddr[7:0] : tx_r;
								end
							end
						end
					end
					M_STOP: begin
						if (phase_r == 2'h0) begin
							sdaN_r <= 1'h0;
						end else if (phase_r == 2'h1) begin
							sclN_r <= 1'h1;
						end else if (phase_r == 2'h2) begin
							sdaN_r <= 1'h1;
						end else begin
							state_r <= M_IDLE;
							reqReady <= 1'h1;
						end
					end
					default: begin
						state_r <= M_IDLE;
					end
				endcase
			end
		end
	end

	assign link.sclDrvLowN = sclN_r;
	assign link.sdaMstOeN = sdaN_r;
endmodule
`default_nettype wire

//--- sep_link_asserts.sv
// protocol checks on the resolved two-wire link lines
// assumes the bench instantiates it beside the link interface
`timescale 1ns/1ps
`default_nettype none
module sep_link_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sclDrvLowN,
	input wire logic sdaMstOeN,
	input wire logic sdaDevOeN,
	input wire logic sclLine,
	input wire logic sdaLine
);
	// ****************************************
	// frame tracking
	// ****************************************
	logic       sclQ, sdaQ, inFrame_r, dir_r, restart_r, silent_r, nack_r;
	logic [3:0] bitCnt_r, byteCnt_r;
	wire logic  sclRise = sclLine & ~sclQ;
	wire logic  startEv = sclLine & sclQ & sdaQ & ~sdaLine;
	wire logic  stopEv = sclLine & sclQ & ~sdaQ & sdaLine;
	wire logic  slotRise = sclRise & inFrame_r & (bitCnt_r == 4'h8);

	// line history for condition detection
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
		end else begin
			sclQ <= sclLine;
			sdaQ <= sdaLine;
		end
	end

	// frame, direction and acknowledge flags
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			inFrame_r <= 1'b0;
			restart_r <= 1'b0;
			silent_r <= 1'b0;
			nack_r <= 1'b0;
			dir_r <= 1'b0;
		end else if (startEv) begin
			inFrame_r <= 1'b1;
			restart_r <= inFrame_r;
			silent_r <= 1'b0;
			nack_r <= 1'b0;
		end else if (stopEv) begin
			inFrame_r <= 1'b0;
		end else if (sclRise && inFrame_r) begin
			if (bitCnt_r == 4'h7 && byteCnt_r == 4'h0)
				dir_r <= sdaLine;
			if (slotRise && byteCnt_r == 4'h0 && sdaLine)
				silent_r <= 1'b1;
			if (slotRise && byteCnt_r != 4'h0 && dir_r && sdaLine)
				nack_r <= 1'b1;
		end
	end

	// bit and byte position within the frame
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bitCnt_r <= 4'h0;
			byteCnt_r <= 4'h0;
		end else if (startEv) begin
			bitCnt_r <= 4'h0;
			byteCnt_r <= 4'h0;
		end else if (slotRise) begin
			bitCnt_r <= 4'h0;
			byteCnt_r <= byteCnt_r + {3'h0, byteCnt_r != 4'hf};
		end else if (sclRise && inFrame_r) begin
			bitCnt_r <= bitCnt_r + 4'h1;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_dev_clk_low: assert property ($changed(sdaDevOeN) |-> !sclLine)
		else $error("memory data changed while clock high");
	a_dev_idle_quiet: assert property (!inFrame_r |-> sdaDevOeN)
		else $error("memory drives data outside a frame");
	a_silent_mismatch: assert property (silent_r |-> sdaDevOeN)
		else $error("memory drives data after refusing control byte");
	a_nack_release: assert property (nack_r |-> sdaDevOeN)
		else $error("memory drives data after master nack");
	a_wr_dev_quiet: assert property (sclRise && inFrame_r && bitCnt_r != 4'h8
		&& (byteCnt_r == 4'h0 || !dir_r) |-> sdaDevOeN)
		else $error("memory drives a bit it should receive");
	a_rd_ack_master: assert property (slotRise && dir_r && byteCnt_r != 4'h0 |-> sdaDevOeN)
		else $error("memory drives the master ack slot");
	a_ctrl_ack: assert property (slotRise && byteCnt_r == 4'h0 && !sdaLine
		|-> !sdaDevOeN && sdaMstOeN && sclDrvLowN)
		else $error("control byte ack not given by memory");
	// a repeated start raises the clock once before data falls
	a_restart_spot: assert property (startEv && inFrame_r
		|-> byteCnt_r == 4'h3 && bitCnt_r == 4'h1)
		else $error("repeated start not right after address");
	a_restart_read: assert property (restart_r && slotRise && byteCnt_r == 4'h0 |-> dir_r)
		else $error("control byte after repeated start not a read");
	a_stop_nack: assert property (stopEv && inFrame_r && dir_r && byteCnt_r > 4'h1 |-> nack_r)
		else $error("read ended without master nack");

	// main scenarios reached
	c_restart: cover property (startEv && inFrame_r);
	c_nack_stop: cover property (stopEv && nack_r);
	c_refused: cover property (stopEv && silent_r);
	c_sequential: cover property (slotRise && dir_r && byteCnt_r == 4'h3);
endmodule
`default_nettype wire

//--- serial_eeprom_read_path_test.sv
// self-checking bench: both link ends joined, reads of every kind
// assumes the package, interface, both ends and link checker compiled first
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_read_path_test
	import sep_pkg::*;
;
	logic              ref_clk = 1'b0;
	logic              rst = 1'b1;
	logic [2:0]        strapCs = 3'h0;
	logic              progBusy = 1'b0;
	logic [ADDR_W-1:0] memAddr, ptrExp;
	logic [DATA_W-1:0] memData, rdData;
	logic              ptrLoaded, reqReady, rdValid, nackSeen;
	logic              reqValid = 1'b0;
	logic              reqRandom = 1'b0;
	logic [2:0]        reqCs = 3'h0;
	logic [15:0]       reqAddr = 16'h0000;
	logic [7:0]        reqCount = 8'h00;
	logic [7:0]        expQ[$];
	int                bad_count = 0, check_count = 0, cycles = 0, loads = 0;
	int                seed = 32'h70b8;

	// array contents as a fixed pattern of the address
	function automatic logic [7:0] patt(input logic [ADDR_W-1:0] a);
		return a[7:0] ^ {a[13:8], 2'h3};
	endfunction
	assign memData = patt(memAddr);

	// free-running clock
	always #5 ref_clk = ~ref_clk;

	// ****************************************
	// both ends and the link
	// ****************************************
	sep_link_if link ();
	sep_mem_end i_sep_mem_end (.ref_clk(ref_clk), .rst(rst), .link(link),
		.chip_select_pin_high(strapCs[2]), .chip_select_pin_mid(strapCs[1]),
		.chip_select_pin_low(strapCs[0]), .progBusy(progBusy), .memAddr(memAddr),
		.memData(memData), .ptrLoaded(ptrLoaded));
	sep_master_end i_sep_master_end (.ref_clk(ref_clk), .rst(rst), .link(link),
		.reqValid(reqValid), .reqRandom(reqRandom), .reqCs(reqCs), .reqAddr(reqAddr),
		.reqCount(reqCount), .reqReady(reqReady), .rdData(rdData), .rdValid(rdValid),
		.nackSeen(nackSeen));
	sep_link_asserts i_sep_link_asserts (.ref_clk(ref_clk), .rst(rst),
		.sclDrvLowN(link.sclDrvLowN), .sdaMstOeN(link.sdaMstOeN),
		.sdaDevOeN(link.sdaDevOeN), .sclLine(link.sclLine), .sdaLine(link.sdaLine));

	// ****************************************
	// compare and report
	// ****************************************
	task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check_flag(input logic got, input logic exp);
		check_data({7'h0, got}, {7'h0, exp});
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// byte monitor, pointer-load counter and hang limit
	always @(posedge ref_clk) begin
		cycles++;
		if (ptrLoaded === 1'b1)
			loads++;
		if (rdValid === 1'b1 && expQ.size() == 0)
			check_data(rdData, 8'hxx);
		else if (rdValid === 1'b1)
			check_data(rdData, expQ.pop_front());
		if (cycles == 40000) begin
			bad_count++;
			final_report();
		end
	end

	// one read request, expected bytes noted first
	task automatic do_read(input string name, input logic rnd, input logic [15:0] addr,
		input logic [7:0] cnt, input logic [2:0] cs, input logic expNack);
		int n;
		n = loads;
		if (rnd)
			ptrExp = addr[13:0];
		for (int i = 0; i < cnt && !expNack; i++)
			expQ.push_back(patt(ptrExp + ADDR_W'(i)));
		if (!expNack)
			ptrExp = ptrExp + ADDR_W'(cnt);
		@(posedge ref_clk);
		#1;
		reqValid = 1'b1;
		reqRandom = rnd;
		reqCs = cs;
		reqAddr = addr;
		reqCount = cnt;
		do @(posedge ref_clk); while (reqReady !== 1'b1);
		#1 reqValid = 1'b0;
		repeat (2) @(posedge ref_clk);
		check_data(8'(expQ.size()), 8'h00);
		check_flag(nackSeen, expNack);
		check_data(8'(loads - n), {7'h0, rnd && !expNack});
		$display("test %s done", name);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		strapCs = 3'($random(seed));
		repeat (10) @(posedge ref_clk);
		#1 rst = 1'b0;
		do_read("wrap", 1'b1, 16'hfffe, 8'h03, strapCs, 1'b0);
		do_read("current", 1'b0, 16'h0000, 8'h01, strapCs, 1'b0);
		do_read("random", 1'b1, 16'($random(seed)), 8'h02, strapCs, 1'b0);
		do_read("follow", 1'b0, 16'h0000, 8'h01, strapCs, 1'b0);
		do_read("mismatch", 1'b0, 16'h0000, 8'h01, strapCs ^ 3'h2, 1'b1);
		#1 progBusy = 1'b1;
		do_read("busy", 1'b0, 16'h0000, 8'h01, strapCs, 1'b1);
		#1 progBusy = 1'b0;
		do_read("resume", 1'b0, 16'h0000, 8'h02, strapCs, 1'b0);
		final_report();
	end
endmodule
`default_nettype wire
